// file: pkg/mcdt_pkg.sv
// constants of the commutation delay timer
package mcdt_pkg;
    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_COUNT   = 8'h00;
    localparam logic [7:0] OFS_PREV    = 8'h04;
    localparam logic [7:0] OFS_LAST    = 8'h08;
    localparam logic [7:0] OFS_COMPARE = 8'h0C;
    localparam logic [7:0] OFS_DEMAG   = 8'h10;
    localparam logic [7:0] OFS_WEIGHT  = 8'h14;
    localparam logic [7:0] OFS_CTRL_A  = 8'h18;
    localparam logic [7:0] OFS_STEP    = 8'h1C;
    localparam logic [7:0] OFS_STATUS  = 8'h20;
    localparam logic [7:0] OFS_MASK    = 8'h24;
    localparam logic [7:0] OFS_CTRL_B  = 8'h28;
    localparam logic [7:0] OFS_PHASE   = 8'h2C;
    localparam logic [7:0] OFS_DEMAG_ADD = 8'h30;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CA_OUTPUT_ENABLE = 0;
    localparam int CA_AUTO_SELECT   = 1;
    localparam int CA_CAPTURE_SEL   = 2;
    localparam int CA_DIRECT_ACCESS = 3;
    localparam int FL_COMMUTATION   = 0;
    localparam int FL_RATIO_INC     = 1;
    localparam int FL_RATIO_DEC     = 2;
    localparam int FL_MULT_OVF      = 3;
    localparam int FL_TIMER_OVF     = 4;
    localparam int MK_COMMUTATION   = 0;
    localparam int MK_RATIO         = 1;
    localparam int MK_MULT_OVF      = 2;
    // ---------------------------------------------------------------
    // values and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [7:0] TIMER_MAX    = 8'hFF;
    localparam logic [7:0] TIMER_PRE_MAX = 8'hFE;
    localparam logic [7:0] SPEEDUP_LIMIT = 8'h55;
    localparam logic [7:0] DEMAG_FOLD   = 8'h7F;
    localparam logic [3:0] STEP_MIN     = 4'h0;
    localparam logic [3:0] STEP_MAX     = 4'hF;
    localparam int         MULT_SHIFT   = 5;
    localparam int         PRESC_W      = 20;
    localparam int         BASE_DIV     = 4;
endpackage

// file: hdl/mcdt_mult.sv
// weight times capture over thirty-two, with eight-bit saturation
`timescale 1ns/1ps
module mcdt_mult (
    input  wire logic [7:0] weight_in,
    input  wire logic [7:0] capture_in,
    output logic      [7:0] result_out,
    output logic            overflow_out
);
    logic [15:0] product;
    logic [10:0] scaled;

    // product and divide by thirty-two
    always_comb begin
        product      = 16'(weight_in) * 16'(capture_in);
        scaled       = product[15:mcdt_pkg::MULT_SHIFT];
        overflow_out = (scaled[10:8] != 3'h0);
        result_out   = overflow_out ? mcdt_pkg::TIMER_MAX : scaled[7:0];
    end
endmodule

// file: hdl/mcdt_top.sv
// commutation delay timer with self-adjusting prescaler and APB registers
// Function
// - switched mode: timer reaching compare raises commutation and clears timer
// - commutation loads preloads, sets commutation flag, interrupts if masked in
// - switched mode: timer overflow raises ratio interrupt when ratio mask set
// - prescaler written only when stopped; requests apply at next commutation
// - one prescaler update per step; increase first, decrease on next step
// - switched mode: zero-cross and demag events never touch the timer
// - auto mode: compare read-only, commutation leaves timer unchanged
// - auto mode zero-cross: capture timer, shift old capture, clear timer
// - auto mode compare is weight times chosen capture over 32
// - multiply overflow writes FFh and raises overflow event
// - auto mode: multiplication is recomputed after every register shift
// - auto mode timer at FFh: prescaler up, shift right, increase flag
// - zero-cross with timer below 55h: prescaler down, shift left, flag
// - prescaler at zero: no decrement and no decrease flag
// - prescaler at 15 and timer FFh: nothing changes, timer clock stops
// - shifts apply to timer, both captures, compare and demag
// - demag sum beyond FFh stored as 7Fh plus half the excess
// - step configuration preloaded, applied at commutation or, in direct access, phase write
// - all timer registers writable while the timer clock is off
`timescale 1ns/1ps
module mcdt_top #(
    parameter int BASE_DIV = mcdt_pkg::BASE_DIV
) (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic        CE_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    input  wire logic        ZERO_CROSS_IN,
    input  wire logic        DEMAG_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    output logic             COMMUTATE_OUT,
    output logic             IRQ_OUT,
    output logic      [3:0]  CTRL_B_ACTIVE_OUT,
    output logic      [7:0]  PHASE_ACTIVE_OUT
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  timer;
        logic [7:0]  prev;
        logic [7:0]  last;
        logic [7:0]  compare;
        logic [7:0]  demag;
        logic [7:0]  weight;
        logic [3:0]  ctrl;
        logic [3:0]  step;
        logic [4:0]  flags;
        logic [2:0]  mask;
        logic [3:0]  ctrlb_pre;
        logic [3:0]  ctrlb_act;
        logic [7:0]  phase_pre;
        logic [7:0]  phase_act;
        logic [19:0] presc;
        logic        stalled;
        logic        recompute;
        logic        commutate;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } mcdt_state_t;

    mcdt_state_t s;
    mcdt_state_t next_s;
    logic [7:0]  mult_result;
    logic        mult_ovf;
    logic        run;
    logic        autom;
    logic        tick;
    logic        comm;
    logic        wr;
    logic        rd;
    logic        hit;
    logic [7:0]  sel_capture;
    logic [8:0]  demag_sum;
    logic [4:0]  hw_set;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] shl_sat(input logic [7:0] v);
        shl_sat = v[7] ? mcdt_pkg::TIMER_MAX : {v[6:0], 1'b0};
    endfunction

    function automatic logic [7:0] shr(input logic [7:0] v);
        shr = {1'b0, v[7:1]};
    endfunction

    function automatic logic [19:0] tick_limit(input logic [3:0] st);
        tick_limit = (20'(BASE_DIV) << st) - 20'h00001;
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a <= mcdt_pkg::OFS_DEMAG_ADD) && (a[1:0] == 2'h0);
    endfunction

    // ---------------------------------------------------------------
    // multiplier
    // ---------------------------------------------------------------
    // capture chosen by select bit
    assign sel_capture = s.ctrl[mcdt_pkg::CA_CAPTURE_SEL] ? s.last : s.prev;

    mcdt_mult u_mult (
        .weight_in    (s.weight),
        .capture_in   (sel_capture),
        .result_out   (mult_result),
        .overflow_out (mult_ovf)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_s           = s;
        next_s.commutate = 1'b0;
        next_s.pready    = 1'b0;
        next_s.pslverr   = 1'b0;
        // clock runs only when enabled and not in direct access
        run   = s.ctrl[mcdt_pkg::CA_OUTPUT_ENABLE] & ~s.ctrl[mcdt_pkg::CA_DIRECT_ACCESS];
        autom = s.ctrl[mcdt_pkg::CA_AUTO_SELECT];
        // tick period doubles per prescaler step
        tick  = (s.presc >= tick_limit(s.step));
        comm  = 1'b0;
        wr    = PSEL_IN & PENABLE_IN & s.pready & PWRITE_IN;
        rd    = PSEL_IN & PENABLE_IN & ~s.pready;
        hit   = known_addr(PADDR_IN);
        demag_sum = 9'(s.compare) + 9'(PWDATA_IN[7:0]);
        if (run) begin
            next_s.presc = tick ? 20'h00000 : 20'(s.presc + 20'h00001);
            if (tick && !autom) begin
                if (s.timer == mcdt_pkg::TIMER_MAX) begin
                    next_s.flags[mcdt_pkg::FL_TIMER_OVF] = 1'b1;
                end
                next_s.timer = 8'(s.timer + 8'h01);
                // compare match commutates and clears timer
                if (8'(s.timer + 8'h01) == s.compare) begin
                    comm         = 1'b1;
                    next_s.timer = mcdt_pkg::RESET_BYTE;
                end
            end else if (tick && !s.stalled) begin
                if (s.timer == mcdt_pkg::TIMER_PRE_MAX && s.step != mcdt_pkg::STEP_MAX) begin
                    next_s.step      = 4'(s.step + 4'h1);
                    next_s.timer     = shr(mcdt_pkg::TIMER_MAX);
                    next_s.prev      = shr(s.prev);
                    next_s.last      = shr(s.last);
                    next_s.compare   = shr(s.compare);
                    next_s.demag     = shr(s.demag);
                    next_s.flags[mcdt_pkg::FL_RATIO_INC] = 1'b1;
                    next_s.recompute = 1'b1;
                end else if (s.timer == mcdt_pkg::TIMER_PRE_MAX) begin
                    next_s.timer   = mcdt_pkg::TIMER_MAX;
                    next_s.stalled = 1'b1;
                end else begin
                    next_s.timer = 8'(s.timer + 8'h01);
                end
                if (8'(s.timer + 8'h01) == s.compare) begin
                    comm = 1'b1;
                end
            end
            // zero-cross only acts in auto mode
            if (autom && ZERO_CROSS_IN) begin
                next_s.last      = s.timer;
                next_s.prev      = s.last;
                next_s.timer     = mcdt_pkg::RESET_BYTE;
                next_s.stalled   = 1'b0;
                next_s.recompute = 1'b1;
                // speed up when timer below limit
                // no decrement at the lowest prescaler
                if (s.timer < mcdt_pkg::SPEEDUP_LIMIT && s.step != mcdt_pkg::STEP_MIN) begin
                    next_s.step    = 4'(s.step - 4'h1);
                    next_s.last    = shl_sat(s.timer);
                    next_s.prev    = shl_sat(s.last);
                    next_s.compare = shl_sat(s.compare);
                    next_s.demag   = shl_sat(s.demag);
                    next_s.presc   = 20'h00000;
                    next_s.flags[mcdt_pkg::FL_RATIO_DEC] = 1'b1;
                end
            end
            if (autom && s.recompute) begin
                next_s.recompute = 1'b0;
                next_s.compare   = mult_result;
                if (mult_ovf) begin
                    next_s.flags[mcdt_pkg::FL_MULT_OVF] = 1'b1;
                end
            end
            // switched-mode ratio requests taken at commutation
            // increase first, decrease one commutation later
            if (comm && !autom) begin
                next_s.presc = 20'h00000;
                if (s.flags[mcdt_pkg::FL_RATIO_INC]) begin
                    next_s.flags[mcdt_pkg::FL_RATIO_INC] = 1'b0;
                    if (s.step != mcdt_pkg::STEP_MAX) begin
                        next_s.step    = 4'(s.step + 4'h1);
                        next_s.prev    = shr(s.prev);
                        next_s.last    = shr(s.last);
                        next_s.compare = shr(s.compare);
                        next_s.demag   = shr(s.demag);
                    end
                end else if (s.flags[mcdt_pkg::FL_RATIO_DEC]) begin
                    next_s.flags[mcdt_pkg::FL_RATIO_DEC] = 1'b0;
                    if (s.step != mcdt_pkg::STEP_MIN) begin
                        next_s.step    = 4'(s.step - 4'h1);
                        next_s.prev    = shl_sat(s.prev);
                        next_s.last    = shl_sat(s.last);
                        next_s.compare = shl_sat(s.compare);
                        next_s.demag   = shl_sat(s.demag);
                    end
                end
            end
            if (comm) begin
                next_s.commutate = 1'b1;
                next_s.flags[mcdt_pkg::FL_COMMUTATION] = 1'b1;
                next_s.ctrlb_act = s.ctrlb_pre;
                next_s.phase_act = s.phase_pre;
            end
        end
        hw_set = next_s.flags & ~s.flags;
        // bus writes, taken on the access edge with pready high
        if (wr && hit) begin
            case (PADDR_IN)
                mcdt_pkg::OFS_COUNT: begin
                    if (!run) next_s.timer = PWDATA_IN[7:0];
                end
                mcdt_pkg::OFS_PREV: begin
                    if (!run) next_s.prev = PWDATA_IN[7:0];
                end
                mcdt_pkg::OFS_LAST: begin
                    if (!run) next_s.last = PWDATA_IN[7:0];
                end
                // compare read-only in running auto mode
                mcdt_pkg::OFS_COMPARE: begin
                    if (!run || !autom) next_s.compare = PWDATA_IN[7:0];
                end
                mcdt_pkg::OFS_DEMAG:  next_s.demag  = PWDATA_IN[7:0];
                mcdt_pkg::OFS_WEIGHT: next_s.weight = PWDATA_IN[7:0];
                mcdt_pkg::OFS_CTRL_A: next_s.ctrl   = PWDATA_IN[3:0];
                // direct prescaler write only while stopped
                mcdt_pkg::OFS_STEP: begin
                    if (!run) next_s.step = PWDATA_IN[3:0];
                end
                mcdt_pkg::OFS_STATUS: begin
                    // writing zero clears; a set in this cycle wins
                    next_s.flags = (next_s.flags & PWDATA_IN[4:0]) | hw_set;
                    if (run && !autom) begin
                        next_s.flags[mcdt_pkg::FL_RATIO_INC] = next_s.flags[mcdt_pkg::FL_RATIO_INC]
                            | PWDATA_IN[mcdt_pkg::FL_RATIO_INC];
                        next_s.flags[mcdt_pkg::FL_RATIO_DEC] = next_s.flags[mcdt_pkg::FL_RATIO_DEC]
                            | PWDATA_IN[mcdt_pkg::FL_RATIO_DEC];
                    end
                end
                mcdt_pkg::OFS_MASK:   next_s.mask      = PWDATA_IN[2:0];
                mcdt_pkg::OFS_CTRL_B: next_s.ctrlb_pre = PWDATA_IN[3:0];
                mcdt_pkg::OFS_PHASE: begin
                    next_s.phase_pre = PWDATA_IN[7:0];
                    // direct access applies on phase write
                    if (s.ctrl[mcdt_pkg::CA_DIRECT_ACCESS]) begin
                        next_s.phase_act = PWDATA_IN[7:0];
                        next_s.ctrlb_act = s.ctrlb_pre;
                    end
                end
                mcdt_pkg::OFS_DEMAG_ADD: begin
                    if (demag_sum[8]) begin
                        next_s.demag = 8'(9'(mcdt_pkg::DEMAG_FOLD)
                            + ((demag_sum - 9'(mcdt_pkg::TIMER_MAX)) >> 1));
                    end else begin
                        next_s.demag = demag_sum[7:0];
                    end
                end
                default: next_s.demag = next_s.demag;
            endcase
        end
        // bus answer, one wait cycle then pready
        if (rd) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = ~hit;
            next_s.prdata  = 32'h00000000;
            if (!PWRITE_IN) begin
                case (PADDR_IN)
                    mcdt_pkg::OFS_COUNT:   next_s.prdata = {24'h000000, s.timer};
                    mcdt_pkg::OFS_PREV:    next_s.prdata = {24'h000000, s.prev};
                    mcdt_pkg::OFS_LAST:    next_s.prdata = {24'h000000, s.last};
                    mcdt_pkg::OFS_COMPARE: next_s.prdata = {24'h000000, s.compare};
                    mcdt_pkg::OFS_DEMAG:   next_s.prdata = {24'h000000, s.demag};
                    mcdt_pkg::OFS_WEIGHT:  next_s.prdata = {24'h000000, s.weight};
                    mcdt_pkg::OFS_CTRL_A:  next_s.prdata = {28'h0000000, s.ctrl};
                    mcdt_pkg::OFS_STEP:    next_s.prdata = {28'h0000000, s.step};
                    mcdt_pkg::OFS_STATUS:  next_s.prdata = {27'h0000000, s.flags};
                    mcdt_pkg::OFS_MASK:    next_s.prdata = {29'h00000000, s.mask};
                    mcdt_pkg::OFS_CTRL_B:  next_s.prdata = {28'h0000000, s.ctrlb_pre};
                    mcdt_pkg::OFS_PHASE:   next_s.prdata = {24'h000000, s.phase_pre};
                    default:               next_s.prdata = 32'h00000000;
                endcase
            end
        end
        next_s.irq = (next_s.flags[mcdt_pkg::FL_COMMUTATION] & next_s.mask[mcdt_pkg::MK_COMMUTATION])
            | ((next_s.flags[mcdt_pkg::FL_RATIO_INC] | next_s.flags[mcdt_pkg::FL_RATIO_DEC]
                | next_s.flags[mcdt_pkg::FL_TIMER_OVF]) & next_s.mask[mcdt_pkg::MK_RATIO])
            | (next_s.flags[mcdt_pkg::FL_MULT_OVF] & next_s.mask[mcdt_pkg::MK_MULT_OVF]);
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            s <= '0;
        end else if (CE_IN) begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign PRDATA_OUT        = s.prdata;
    assign PREADY_OUT        = s.pready;
    assign PSLVERR_OUT       = s.pslverr;
    assign COMMUTATE_OUT     = s.commutate;
    assign IRQ_OUT           = s.irq;
    assign CTRL_B_ACTIVE_OUT = s.ctrlb_act;
    assign PHASE_ACTIVE_OUT  = s.phase_act;
endmodule

// file: sim/mcdt_checker.sv
// port assertions for the commutation delay timer
`timescale 1ns/1ps
module mcdt_checker (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic        CE_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    input  wire logic        ZERO_CROSS_IN,
    input  wire logic        DEMAG_IN,
    input  wire logic [31:0] PRDATA_OUT,
    input  wire logic        PREADY_OUT,
    input  wire logic        PSLVERR_OUT,
    input  wire logic        COMMUTATE_OUT,
    input  wire logic        IRQ_OUT,
    input  wire logic [3:0]  CTRL_B_ACTIVE_OUT,
    input  wire logic [7:0]  PHASE_ACTIVE_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    // completing phase write and waiting access phase
    logic ph_wr;
    assign ph_wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN
                   && PADDR_IN == mcdt_pkg::OFS_PHASE;
    sequence s_wait;
        PSEL_IN && PENABLE_IN && !PREADY_OUT && CE_IN;
    endsequence
    sequence s_unmapped_rd;
        s_wait ##0 (!PWRITE_IN && PADDR_IN > mcdt_pkg::OFS_DEMAG_ADD);
    endsequence
    a_ready_once: assert property (PREADY_OUT && CE_IN |=> !PREADY_OUT)
        else $error("ready held too long");
    a_ready_after: assert property (s_wait |=> PREADY_OUT)
        else $error("ready not one cycle after access");
    a_ready_cause: assert property (PREADY_OUT |-> $past(PSEL_IN && PENABLE_IN))
        else $error("ready without access phase");
    a_err_unmapped: assert property (s_unmapped_rd |=> PSLVERR_OUT && PRDATA_OUT == 32'h0)
        else $error("unmapped read not refused");
    a_err_only_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    a_upper_zero: assert property (PREADY_OUT && !PWRITE_IN |-> PRDATA_OUT[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_comm_pulse: assert property (COMMUTATE_OUT && CE_IN |=> !COMMUTATE_OUT)
        else $error("commutation pulse too long");
    a_active_hold: assert property (!$stable({CTRL_B_ACTIVE_OUT, PHASE_ACTIVE_OUT})
        |-> COMMUTATE_OUT || $past(COMMUTATE_OUT) || $past(ph_wr) || $past(ph_wr, 2))
        else $error("active config changed outside step");
    a_ce_freeze: assert property (!CE_IN |=> $stable({PRDATA_OUT, COMMUTATE_OUT, IRQ_OUT}))
        else $error("outputs moved while clock disabled");
endmodule

// file: sim/mcdt_rotor_model.sv
// rotor position detector stand-in: demag pulse then zero-cross pulse
`timescale 1ns/1ps
module mcdt_rotor_model #(
    parameter int DELAY = 3
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic req_in,
    output logic      zero_cross_out,
    output logic      demag_out
);
    int cnt;
    // countdown from a request, events at count values two and one
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= 0;
        end else if (req_in) begin
            cnt <= DELAY + 2;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    // demag event arrives before each zero-cross
    assign demag_out      = (cnt == 2);
    assign zero_cross_out = (cnt == 1);
endmodule

// file: sim/testbench.sv
// self-checking bench for the commutation delay timer
`timescale 1ns/1ps
module testbench;
    typedef struct {logic err; logic [31:0] exp; logic [31:0] msk;} mcdt_note_t;
    mcdt_note_t  notes[$];
    logic        clk, rst_n, ce, psel, pen, pwr, zreq, pready, pslverr, comm, irq, zc, dm;
    logic [7:0]  paddr, ph_act, w;
    logic [31:0] pwdata, prdata;
    logic [3:0]  cb_act;
    int          err_count = 0;
    int          n_tests = 0;
    mcdt_top #(.BASE_DIV(1)) mcdt_top_inst (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .ZERO_CROSS_IN(zc), .DEMAG_IN(dm), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .COMMUTATE_OUT(comm), .IRQ_OUT(irq),
        .CTRL_B_ACTIVE_OUT(cb_act), .PHASE_ACTIVE_OUT(ph_act));
    mcdt_rotor_model mcdt_rotor_model_inst (.clk_in(clk), .rst_n_in(rst_n), .req_in(zreq),
        .zero_cross_out(zc), .demag_out(dm));
    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t bus value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t pin value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // apb master: hold request until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic e);
        int t;
        notes.push_back('{e, d, m});
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        t = 0;
        do begin @(posedge clk); t++; end while (pready !== 1'b1 && t < 50);
        if (pready !== 1'b1) chk_pin(8'h0, 8'h1);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic wait_ev(input logic z);
        int t;
        t = 0;
        // skip a pulse launched at the calling edge
        @(posedge clk);
        do begin @(posedge clk); t++; end while ((z ? zc : comm) !== 1'b1 && t < 2000);
        if (t >= 2000) chk_pin(8'h0, 8'h1);
        repeat (2) @(posedge clk);
    endtask
    // bus result monitor: oldest note against each answer
    always @(posedge clk) if (pready === 1'b1) begin
        mcdt_note_t n;
        n = notes.pop_front();
        chk_bus({31'h0, pslverr}, {31'h0, n.err});
        if (n.msk != 0) chk_bus(prdata & n.msk, n.exp & n.msk);
    end
    // free-running clock and watchdog
    initial begin clk = 1'b0; forever #2.5 clk = ~clk; end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("Error %0t watchdog expired", $time);
        conclude();
    end
    initial begin
        rst_n = 0; ce = 1; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0; zreq = 0;
        w = 8'($urandom(81765));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) apb(0, 8'(i * 4), 32'h0, '1, 0);
        apb(0, 8'h3C, 32'h0, '1, 1);
        $display("reset values test done");
        // start in switched mode; compare never zero
        wr(mcdt_pkg::OFS_STEP, 0); wr(mcdt_pkg::OFS_COMPARE, 32'h20); wr(mcdt_pkg::OFS_CTRL_B, 5);
        wr(mcdt_pkg::OFS_PHASE, 32'hA5); wr(mcdt_pkg::OFS_MASK, 1); wr(mcdt_pkg::OFS_CTRL_A, 1);
        wait_ev(0);
        chk_pin({4'h0, cb_act}, 8'h05);
        chk_pin(ph_act, 8'hA5);
        chk_pin({7'h0, irq}, 8'h01);
        apb(0, mcdt_pkg::OFS_STATUS, 32'h1, 32'h1, 0);
        apb(0, mcdt_pkg::OFS_COMPARE, 32'h20, '1, 0);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        wr(mcdt_pkg::OFS_STATUS, 32'h06);
        wait_ev(0);
        apb(0, mcdt_pkg::OFS_STEP, 32'h1, '1, 0);
        wait_ev(0);
        apb(0, mcdt_pkg::OFS_STEP, 32'h0, '1, 0);
        $display("switched mode test done");
        w = 8'h01 + w % 8'h3F;
        wr(mcdt_pkg::OFS_CTRL_A, 0); wr(mcdt_pkg::OFS_COUNT, 0); wr(mcdt_pkg::OFS_LAST, 32'h40);
        // preload both captures before auto start
        wr(mcdt_pkg::OFS_PREV, 32'h40);
        wr(mcdt_pkg::OFS_WEIGHT, {24'h0, w}); wr(mcdt_pkg::OFS_STATUS, 0);
        wr(mcdt_pkg::OFS_CTRL_A, 3);
        zreq <= 1'b1; @(posedge clk); zreq <= 1'b0; wait_ev(1);
        apb(0, mcdt_pkg::OFS_PREV, 32'h40, '1, 0);
        apb(0, mcdt_pkg::OFS_COMPARE, 32'(w) * 32'h40 / 32, '1, 0);
        wr(mcdt_pkg::OFS_COMPARE, 32'h11);
        apb(0, mcdt_pkg::OFS_COMPARE, 32'(w) * 32'h40 / 32, '1, 0);
        apb(0, mcdt_pkg::OFS_STEP, 32'h0, '1, 0);
        apb(0, mcdt_pkg::OFS_STATUS, 32'h0, 32'h4, 0);
        $display("auto mode test done");
        wr(mcdt_pkg::OFS_CTRL_A, 0); wr(mcdt_pkg::OFS_COUNT, 0); wr(mcdt_pkg::OFS_LAST, 32'hC0);
        // start one ratio up so the early zero-cross speeds up
        wr(mcdt_pkg::OFS_STEP, 1);
        wr(mcdt_pkg::OFS_WEIGHT, 32'hFF); wr(mcdt_pkg::OFS_STATUS, 0); wr(mcdt_pkg::OFS_CTRL_A, 3);
        zreq <= 1'b1; @(posedge clk); zreq <= 1'b0; wait_ev(1);
        apb(0, mcdt_pkg::OFS_COMPARE, 32'hFF, '1, 0);
        apb(0, mcdt_pkg::OFS_STATUS, 32'h8, 32'h8, 0);
        apb(0, mcdt_pkg::OFS_PREV, 32'hFF, '1, 0);
        apb(0, mcdt_pkg::OFS_STATUS, 32'h4, 32'h4, 0);
        repeat (260) @(posedge clk);
        apb(0, mcdt_pkg::OFS_STEP, 32'h1, '1, 0);
        apb(0, mcdt_pkg::OFS_STATUS, 32'h2, 32'h2, 0);
        $display("overflow test done");
        wr(mcdt_pkg::OFS_CTRL_A, 8);
        wr(mcdt_pkg::OFS_COMPARE, 32'hF0);
        wr(mcdt_pkg::OFS_DEMAG_ADD, 32'h20);
        apb(0, mcdt_pkg::OFS_DEMAG, 32'h87, '1, 0);
        wr(mcdt_pkg::OFS_PHASE, 32'h3C);
        @(posedge clk);
        chk_pin(ph_act, 8'h3C);
        $display("demag and direct access test done");
        conclude();
    end
endmodule
bind mcdt_top mcdt_checker mcdt_checker_inst (.SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN),
    .CE_IN(CE_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
    .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .ZERO_CROSS_IN(ZERO_CROSS_IN),
    .DEMAG_IN(DEMAG_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .COMMUTATE_OUT(COMMUTATE_OUT), .IRQ_OUT(IRQ_OUT),
    .CTRL_B_ACTIVE_OUT(CTRL_B_ACTIVE_OUT), .PHASE_ACTIVE_OUT(PHASE_ACTIVE_OUT));
